// >>> verilog/serial_channel_pkg.sv
// constants and field layouts for the tagged serial channel transceiver
package serial_channel_pkg;
    localparam int CORE_CLK_HZ = 125000000;
    localparam int OSC_HZ = 15000000;
    // register indices
    localparam logic [3:0] REG_CHANNEL_SELECT = 4'h0;
    localparam logic [3:0] REG_ADDRESS_COMPARE = 4'h1;
    localparam logic [3:0] REG_RECEIVE_FUNCTION = 4'h3;
    localparam logic [3:0] REG_SIXTH_CONTROL = 4'h6;
    localparam logic [3:0] REG_SEVENTH_CONTROL = 4'h7;
    localparam logic [3:0] REG_TX_DATA = 4'h8;
    localparam logic [3:0] REG_RX_DATA = 4'h9;
    localparam logic [3:0] REG_STATUS = 4'hA;
    localparam logic [3:0] REG_CRC = 4'hB;
    // word framing
    localparam int WORD_BITS = 20;
    localparam int DATA_BITS = 16;
    localparam int DATA_FIRST = 2;
    localparam int DATA_LAST = 17;
    localparam int REPEAT_DELAY_BITS = 2;
    // channel_select_word fields
    localparam int SEL_LSB = 0;
    localparam int RATE_LSB = 2;
    localparam int RATE_W = 12;
    // sixth / seventh control word fields
    localparam int CTL_LINE_BIT = 3;
    localparam int CTL_ADDR_BIT = 2;
    localparam int REPEAT_BIT = 15;
    localparam int CRC_SRC_BIT = 12;
    localparam int CRC_TEST_BIT = 13;
    localparam int CRC_TX_BIT = 14;
    localparam int TAG_BIT = 15;
    // receive function field: compare group 8..11, no-compare 12..15
    localparam int FN_CMP_LSB = 8;
    localparam int FN_NOCMP_LSB = 12;
    localparam int ADDR_LSB = 9;
    localparam int ADDR_W = 6;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [11:0] RATE_RESET = 12'h00F;
endpackage

// >>> verilog/tagged_serial_channel_transceiver.sv
// four channel tagged serial word transceiver with crc and handshakes
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module tagged_serial_channel_transceiver #(
    parameter int CHANNELS = 4
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WRITE,
    input wire logic I_READ,
    output logic [15:0] O_RDATA,
    input wire logic [CHANNELS-1:0] I_RX_LINE,
    input wire logic [CHANNELS-1:0] I_SET_READY,
    input wire logic [CHANNELS-1:0] I_CLEAR_TO_SEND,
    output logic [CHANNELS-1:0] O_TX_LINE,
    output logic [CHANNELS-1:0] O_TERMINAL_READY,
    output logic [CHANNELS-1:0] O_REQUEST_TO_SEND,
    input wire logic I_PROGRAM_READY,
    output logic O_SERVICE_REQUEST,
    output logic O_DEVICE_END,
    output logic O_JUMP_MET,
    output logic O_FUNCTION_INTERRUPT,
    output logic O_SERVICE_INTERRUPT,
    output logic O_CRC_INTERRUPT,
    output logic O_STATUS_CLOCK
);
    import serial_channel_pkg::*;
    // after nineteen shifts frame bit k sits at position k+1
    localparam int RX_TAG_POS = 2;
    localparam int RX_ADDR_POS = RX_TAG_POS + 1 + ADDR_LSB;

    typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_STORE} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tx_state_t;

    typedef struct packed {
        logic [15:0] channel_select_word;
        logic [15:0] address_compare_word;
        logic [15:0] receive_function_word;
        logic [15:0] sixth_control_word;
        logic [15:0] seventh_control_word;
        logic [13:0] osc_acc;
        logic [11:0] baud_cnt;
        logic [3:0] rx_pipe;
        logic [3:0] rx_sub;
        logic [4:0] rx_bit;
        logic [WORD_BITS-1:0] rx_shift;
        rx_state_t rx_state;
        logic [17:0] rx_buffer;
        logic rx_word_available;
        logic read_ready_flop;
        logic overrun_flag;
        logic compare_hit;
        logic tag_seen;
        logic [3:0] tx_sub;
        logic [4:0] tx_bit;
        logic [WORD_BITS-1:0] tx_shift;
        tx_state_t tx_state;
        logic [15:0] tx_hold;
        logic tx_busy_flop;
        logic tx_crc_sel;
        logic tx_out;
        logic [REPEAT_DELAY_BITS*16-1:0] rep_delay;
        logic [15:0] crc;
        logic crc_error_flop;
        logic [CHANNELS-1:0] terminal_ready;
        logic [CHANNELS-1:0] request_to_send;
        logic [CHANNELS-1:0] dsr_s1;
        logic [CHANNELS-1:0] dsr_s2;
        logic [CHANNELS-1:0] dsr_s3;
        logic [CHANNELS-1:0] rxl_s1;
        logic [CHANNELS-1:0] rxl_s2;
        logic [CHANNELS-1:0] rxl_s3;
        logic [CHANNELS-1:0] cts_s1;
        logic [CHANNELS-1:0] cts_s2;
        logic [CHANNELS-1:0] cts_s3;
        logic [CHANNELS-1:0] dsr_q;
        logic [CHANNELS-1:0] rxl_q;
        logic [CHANNELS-1:0] cts_q;
        logic service_valid;
        logic [1:0] channel_number;
        logic service_send;
        logic sense;
        logic [15:0] rdata;
        logic [CHANNELS-1:0] tx_line;
        logic service_request;
        logic device_end;
        logic jump_met;
        logic func_int;
        logic svc_int;
        logic crc_int;
        logic status_clock;
    } state_t;

    state_t r;
    state_t next_r;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic d);
        logic fb;
        fb = c[15] ^ d;
        crc_step = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    endfunction

    // frame bit i: 0 start, 1 tag, 2..17 data lsb first, 18,19 stop
    function automatic logic [WORD_BITS-1:0] frame(input logic tag,
                                                  input logic [15:0] d);
        frame = {2'b11, d, tag, 1'b0};
    endfunction

    logic [1:0] sel;
    logic baud_tick;
    logic rx_in;
    logic [5:0] addr_bits;
    logic [3:0] fn;
    logic cts_sel;
    logic crc_src_tx;
    logic [CHANNELS-1:0] dsr_new;
    logic [CHANNELS-1:0] start_other;
    logic dsr_drop;
    logic rep_bit;

    always_comb begin
        next_r = r;
        sel = r.channel_select_word[SEL_LSB +: 2];
        crc_src_tx = r.seventh_control_word[CRC_SRC_BIT];
        addr_bits = '0;
        fn = '0;
        baud_tick = 1'b0;
        next_r.status_clock = 1'b0;
        next_r.device_end = 1'b0;
        next_r.func_int = 1'b0;
        next_r.svc_int = 1'b0;
        next_r.crc_int = 1'b0;

        // synchronisers: a change counts when stages two and three agree
        next_r.dsr_s1 = I_SET_READY;
        next_r.dsr_s2 = r.dsr_s1;
        next_r.dsr_s3 = r.dsr_s2;
        next_r.rxl_s1 = I_RX_LINE;
        next_r.rxl_s2 = r.rxl_s1;
        next_r.rxl_s3 = r.rxl_s2;
        next_r.cts_s1 = I_CLEAR_TO_SEND;
        next_r.cts_s2 = r.cts_s1;
        next_r.cts_s3 = r.cts_s2;
        for (int c = 0; c < CHANNELS; c++) begin
            if (r.dsr_s2[c] == r.dsr_s3[c]) begin
                next_r.dsr_q[c] = r.dsr_s3[c];
            end
            if (r.rxl_s2[c] == r.rxl_s3[c]) begin
                next_r.rxl_q[c] = r.rxl_s3[c];
            end
            if (r.cts_s2[c] == r.cts_s3[c]) begin
                next_r.cts_q[c] = r.cts_s3[c];
            end
        end
        rx_in = r.rxl_q[sel];
        cts_sel = r.cts_q[sel];

        // oscillator enable from core clock, then baud counter
        if (r.osc_acc >= 14'(CORE_CLK_HZ / 10000 - OSC_HZ / 10000)) begin
            next_r.osc_acc = 14'(r.osc_acc + OSC_HZ / 10000
                                 - CORE_CLK_HZ / 10000);
            if (r.baud_cnt == 12'h000) begin
                next_r.baud_cnt = r.channel_select_word[RATE_LSB +: RATE_W]
                                  ;
                baud_tick = 1'b1;
            end else begin
                next_r.baud_cnt = r.baud_cnt - 12'h001;
            end
        end else begin
            next_r.osc_acc = 14'(r.osc_acc + OSC_HZ / 10000);
        end

        // receiver: 16 ticks per bit
        unique case (r.rx_state)
            RX_IDLE: begin
                if (!rx_in && baud_tick) begin
                    next_r.rx_state = RX_SHIFT;
                    next_r.rx_sub = 4'h0;
                    next_r.rx_bit = 5'h00;
                end
            end
            RX_SHIFT: begin
                if (baud_tick) begin
                    next_r.rx_sub = r.rx_sub + 4'h1;
                    if (r.rx_sub == 4'h7) begin
                        next_r.rx_shift = {rx_in, r.rx_shift[19:1]};
                        next_r.rx_bit = r.rx_bit + 5'h01;
                        if (r.rx_bit == 5'h00 && rx_in) begin
                            next_r.rx_state = RX_IDLE;
                        end else if (r.rx_bit == 5'(WORD_BITS - 2)) begin
                            next_r.rx_state = RX_STORE;
                        end
                        if (r.rx_bit >= 5'(DATA_FIRST)
                            && r.rx_bit <= 5'(DATA_LAST) && !crc_src_tx) begin
                            next_r.crc = crc_step(r.crc, rx_in);
                        end
                    end
                end
            end
            RX_STORE: begin
                next_r.rx_buffer = r.rx_shift[19:2];
                next_r.status_clock = 1'b1;
                addr_bits = r.rx_shift[RX_ADDR_POS +: ADDR_W];
                next_r.compare_hit = (addr_bits ==
                    r.address_compare_word[ADDR_W-1:0]);
                next_r.tag_seen = r.rx_shift[RX_TAG_POS];
                if (r.rx_word_available) begin
                    next_r.overrun_flag = 1'b1;
                end
                if (r.rx_shift[RX_TAG_POS]) begin
                    fn = next_r.compare_hit
                        ? r.receive_function_word[FN_CMP_LSB +: 4]
                        : r.receive_function_word[FN_NOCMP_LSB +: 4];
                    if (fn[0]) begin
                        next_r.read_ready_flop = 1'b1;
                        next_r.rx_word_available = 1'b0;
                    end
                    next_r.device_end = fn[1];
                    if (fn[2]) begin
                        next_r.jump_met = I_PROGRAM_READY;
                    end
                    next_r.func_int = fn[3];
                end else if (!r.sixth_control_word[REPEAT_BIT]) begin
                    next_r.rx_word_available = 1'b1;
                    next_r.read_ready_flop = 1'b0;
                end
                next_r.rx_shift = '0;
                next_r.rx_bit = 5'h00;
                next_r.rx_state = RX_IDLE;
            end
            default: next_r.rx_state = RX_IDLE;
        endcase

        // repeat path: delay line of two bit times in ticks
        rep_bit = r.rep_delay[REPEAT_DELAY_BITS*16-1];
        if (baud_tick) begin
            next_r.rep_delay = {r.rep_delay[REPEAT_DELAY_BITS*16-2:0],
                                rx_in};
        end

        // transmitter
        unique case (r.tx_state)
            TX_IDLE: begin
                if (r.tx_busy_flop) begin
                    next_r.tx_state = TX_WAIT;
                    next_r.tx_shift = frame(r.seventh_control_word[TAG_BIT],
                        r.tx_crc_sel ? r.crc : r.tx_hold);
                end
            end
            TX_WAIT: begin
                if (cts_sel && r.request_to_send[sel]) begin
                    next_r.tx_state = TX_SHIFT;
                    next_r.tx_sub = 4'h0;
                    next_r.tx_bit = 5'h00;
                end
            end
            TX_SHIFT: begin
                if (baud_tick) begin
                    next_r.tx_sub = r.tx_sub + 4'h1;
                    if (r.tx_sub == 4'hF) begin
                        next_r.tx_shift = {1'b1, r.tx_shift[19:1]};
                        next_r.tx_bit = r.tx_bit + 5'h01;
                        if (r.tx_bit >= 5'(DATA_FIRST)
                            && r.tx_bit <= 5'(DATA_LAST) && crc_src_tx
                            && !r.tx_crc_sel) begin
                            next_r.crc = crc_step(r.crc, r.tx_shift[0]);
                        end
                        if (r.tx_bit == 5'(WORD_BITS - 1)) begin
                            next_r.tx_busy_flop = 1'b0;
                            next_r.tx_state = TX_IDLE;
                        end
                    end
                end
            end
            default: next_r.tx_state = TX_IDLE;
        endcase
        if (r.sixth_control_word[REPEAT_BIT]) begin
            next_r.tx_out = rep_bit;
        end else begin
            next_r.tx_out = (r.tx_state == TX_SHIFT) ? r.tx_shift[0] : 1'b1;
        end
        for (int c = 0; c < CHANNELS; c++) begin
            next_r.tx_line[c] = (c[1:0] == sel) ? r.tx_out : 1'b1;
        end

        // channel monitors and priority decoder
        dsr_new = '0;
        start_other = '0;
        dsr_drop = r.dsr_q[sel] && !r.dsr_s2[sel] && !r.dsr_s3[sel];
        for (int c = 0; c < CHANNELS; c++) begin
            dsr_new[c] = !r.dsr_q[c] && r.dsr_s2[c] && r.dsr_s3[c];
            if (c[1:0] != sel && r.rxl_q[c] && !r.rxl_s2[c]
                && !r.rxl_s3[c]) begin
                start_other[c] = 1'b1;
            end
        end
        if (!r.service_valid) begin
            if (dsr_drop) begin
                next_r.service_valid = 1'b1;
                next_r.channel_number = sel;
                next_r.service_send = 1'b0;
                next_r.svc_int = 1'b1;
            end else begin
                for (int c = CHANNELS - 1; c >= 0; c--) begin
                    if (dsr_new[c] || start_other[c]) begin
                        next_r.service_valid = 1'b1;
                        next_r.channel_number = c[1:0];
                        next_r.service_send = start_other[c];
                        next_r.svc_int = 1'b1;
                    end
                end
            end
        end
        next_r.sense = |(r.dsr_q & r.terminal_ready);

        next_r.service_request = r.rx_word_available & ~r.read_ready_flop;

        // register port
        if (I_WRITE) begin
            unique case (I_ADDR)
                REG_CHANNEL_SELECT: next_r.channel_select_word = I_WDATA;
                REG_ADDRESS_COMPARE: next_r.address_compare_word = I_WDATA;
                REG_RECEIVE_FUNCTION: next_r.receive_function_word = I_WDATA;
                REG_SIXTH_CONTROL: begin
                    next_r.sixth_control_word = I_WDATA;
                    next_r.terminal_ready[sel] =
                        I_WDATA[CTL_LINE_BIT] ^ I_WDATA[CTL_ADDR_BIT]
                        ^ I_WDATA[CTL_ADDR_BIT];
                    next_r.service_valid = next_r.svc_int;
                end
                REG_SEVENTH_CONTROL: begin
                    next_r.seventh_control_word = I_WDATA;
                    next_r.request_to_send[sel] =
                        I_WDATA[CTL_LINE_BIT];
                    next_r.service_valid = next_r.svc_int;
                    if (I_WDATA[CRC_TEST_BIT]) begin
                        next_r.crc_error_flop = |r.crc;
                        next_r.crc_int = |r.crc;
                        next_r.crc = CRC_INIT;
                    end
                end
                REG_TX_DATA: begin
                    if (r.tx_state == TX_IDLE) begin
                        next_r.tx_hold = I_WDATA;
                        next_r.tx_crc_sel = r.seventh_control_word[CRC_TX_BIT];
                        next_r.tx_busy_flop = 1'b1;
                    end
                end
                REG_STATUS: begin
                    next_r.overrun_flag = 1'b0;
                    next_r.crc_error_flop = 1'b0;
                end
                default: begin
                end
            endcase
        end
        if (I_READ) begin
            unique case (I_ADDR)
                REG_CHANNEL_SELECT: next_r.rdata = r.channel_select_word;
                REG_ADDRESS_COMPARE: next_r.rdata = r.address_compare_word;
                REG_RECEIVE_FUNCTION: next_r.rdata = r.receive_function_word;
                REG_SIXTH_CONTROL: next_r.rdata = r.sixth_control_word;
                REG_SEVENTH_CONTROL: next_r.rdata = r.seventh_control_word;
                REG_TX_DATA: next_r.rdata = r.tx_hold;
                REG_RX_DATA: begin
                    next_r.rdata = r.rx_buffer[16:1];
                    next_r.rx_word_available = 1'b0;
                    next_r.read_ready_flop = 1'b0;
                end
                REG_STATUS: next_r.rdata = {r.tx_busy_flop,
                    r.rx_word_available, r.read_ready_flop, 2'b00,
                    r.service_valid, r.service_send, r.channel_number,
                    r.sense, r.crc_error_flop, r.overrun_flag,
                    r.tag_seen, r.compare_hit, r.jump_met, 1'b0};
                REG_CRC: next_r.rdata = r.crc;
                default: next_r.rdata = 16'h0000;
            endcase
        end else begin
            next_r.rdata = 16'h0000;
        end
        // hardware sets of overrun_flag and rx_word_available win over software clears
        if (r.rx_state == RX_STORE && r.rx_word_available) begin
            next_r.overrun_flag = 1'b1;
        end
        if (r.rx_state == RX_STORE && !r.rx_shift[RX_TAG_POS]
            && !r.sixth_control_word[REPEAT_BIT]) begin
            next_r.rx_word_available = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            r <= '0;
            r.channel_select_word <= {2'h0, RATE_RESET, 2'h0};
            r.tx_out <= 1'b1;
            r.tx_line <= '1;
            r.rep_delay <= '1;
            r.rxl_s1 <= '1;
            r.rxl_s2 <= '1;
            r.rxl_s3 <= '1;
            r.rxl_q <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign O_RDATA = r.rdata;
    assign O_TX_LINE = r.tx_line;
    assign O_TERMINAL_READY = r.terminal_ready;
    assign O_REQUEST_TO_SEND = r.request_to_send;
    assign O_SERVICE_REQUEST = r.service_request;
    assign O_DEVICE_END = r.device_end;
    assign O_JUMP_MET = r.jump_met;
    assign O_FUNCTION_INTERRUPT = r.func_int;
    assign O_SERVICE_INTERRUPT = r.svc_int;
    assign O_CRC_INTERRUPT = r.crc_int;
    assign O_STATUS_CLOCK = r.status_clock;
endmodule

// >>> tb/serial_channel_assertions.sv
// port checker for the tagged serial channel transceiver
`timescale 1ns/100ps
module serial_channel_checker #(
    parameter int CHANNELS = 4
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic [3:0] I_ADDR,
    input wire logic I_WRITE,
    input wire logic I_READ,
    input wire logic [CHANNELS-1:0] O_TX_LINE,
    input wire logic [CHANNELS-1:0] O_TERMINAL_READY,
    input wire logic [CHANNELS-1:0] O_REQUEST_TO_SEND,
    input wire logic O_SERVICE_REQUEST,
    input wire logic O_DEVICE_END,
    input wire logic O_SERVICE_INTERRUPT,
    input wire logic O_CRC_INTERRUPT,
    input wire logic O_STATUS_CLOCK
);
    import serial_channel_pkg::*;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    sequence rx_read;
        I_READ && I_ADDR == REG_RX_DATA;
    endsequence
    sequence tr_idle;
        !(I_WRITE && I_ADDR == REG_SIXTH_CONTROL);
    endsequence
    sequence rts_idle;
        !(I_WRITE && I_ADDR == REG_SEVENTH_CONTROL);
    endsequence
    chk_request_drop: assert property (rx_read |-> ##2 !O_SERVICE_REQUEST)
        else $error("service request kept after data read");
    chk_status_pulse: assert property (O_STATUS_CLOCK |=> !O_STATUS_CLOCK)
        else $error("status clock longer than one cycle");
    chk_end_pulse: assert property (O_DEVICE_END |=> !O_DEVICE_END)
        else $error("device end longer than one cycle");
    chk_svc_pulse: assert property (O_SERVICE_INTERRUPT |=> !O_SERVICE_INTERRUPT)
        else $error("service interrupt longer than one cycle");
    chk_crc_pulse: assert property (O_CRC_INTERRUPT |=> !O_CRC_INTERRUPT)
        else $error("crc interrupt longer than one cycle");
    chk_ready_hold: assert property (tr_idle |=> $stable(O_TERMINAL_READY))
        else $error("terminal ready moved without a write");
    chk_rts_hold: assert property (rts_idle |=> $stable(O_REQUEST_TO_SEND))
        else $error("request to send moved without a write");
    chk_tx_quiet: assert property (O_REQUEST_TO_SEND == '0 |-> O_TX_LINE == '1)
        else $error("line active without request to send");
endmodule

// >>> tb/remote_station_model.sv
// remote station: looped handshakes, word sender and word catcher
`timescale 1ns/100ps
module remote_station_model #(
    parameter real BIT_NS = 1066.7
) (
    input wire logic [3:0] i_tx_line,
    input wire logic [3:0] i_terminal_ready,
    input wire logic [3:0] i_request_to_send,
    output logic [3:0] o_rx_line,
    output logic [3:0] o_set_ready,
    output logic [3:0] o_clear_to_send
);
    logic [19:0] got_frame;
    assign o_set_ready = i_terminal_ready;
    assign o_clear_to_send = i_request_to_send;
    initial o_rx_line = 4'hF;
    task automatic send_word(input int ch, input logic tg,
                             input logic [15:0] d);
        logic [19:0] frame;
        frame = {2'b11, d, tg, 1'b0};
        for (int i = 0; i < 20; i++) begin
            o_rx_line[ch] = frame[i];
            #(BIT_NS);
        end
    endtask
    task automatic take_word(input int ch);
        @(negedge i_tx_line[ch]);
        #(BIT_NS / 2);
        for (int i = 0; i < 20; i++) begin
            got_frame[i] = i_tx_line[ch];
            #(BIT_NS);
        end
    endtask
endmodule

// >>> tb/tagged_serial_channel_transceiver_tb_top.sv
// self-checking bench for the tagged serial channel transceiver
`timescale 1ns/100ps
module tagged_serial_channel_transceiver_tb_top;
    import serial_channel_pkg::*;
    localparam int CHANNELS = 4;
    typedef struct packed {logic [1:0] ch; logic [15:0] d;} row_t;
    row_t rows [4] = '{'{2'h0, 16'h0000}, '{2'h1, 16'hFFFF},
                       '{2'h2, 16'hA5C3}, '{2'h3, 16'h0001}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic prog_rdy = 1'b0;
    logic [15:0] rdata;
    logic [3:0] rx, sr, cts, tx, tr, rts;
    logic svc_req, dev_end, jump, fn_int, svc_int, crc_int, stat_clk;
    int err_count = 0;
    int samples_checked = 0;
    int n_end = 0;
    int n_stat = 0;
    int n_svc = 0;
    int n_fn = 0;
    int n_crc = 0;
    tagged_serial_channel_transceiver #(.CHANNELS(CHANNELS)) dut_u (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WRITE(wr_s), .I_READ(rd_s), .O_RDATA(rdata), .I_RX_LINE(rx),
        .I_SET_READY(sr), .I_CLEAR_TO_SEND(cts), .O_TX_LINE(tx),
        .O_TERMINAL_READY(tr), .O_REQUEST_TO_SEND(rts),
        .I_PROGRAM_READY(prog_rdy), .O_SERVICE_REQUEST(svc_req),
        .O_DEVICE_END(dev_end), .O_JUMP_MET(jump),
        .O_FUNCTION_INTERRUPT(fn_int), .O_SERVICE_INTERRUPT(svc_int),
        .O_CRC_INTERRUPT(crc_int), .O_STATUS_CLOCK(stat_clk));
    remote_station_model rs_u (.i_tx_line(tx), .i_terminal_ready(tr),
        .i_request_to_send(rts), .o_rx_line(rx), .o_set_ready(sr),
        .o_clear_to_send(cts));
    initial forever #4 clk = ~clk;
    always @(posedge clk) if (!rst) begin
        n_end += dev_end;
        n_stat += stat_clk;
        n_svc += svc_int;
        n_fn += fn_int;
        n_crc += crc_int;
    end
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // crc-16 over data bits in line order, zero start
    function automatic logic [15:0] crc_of(input logic [15:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 16; i++)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rx_word(input int ch, input logic tg, input logic [15:0] d);
        rs_u.send_word(ch, tg, d);
        repeat (8) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial begin
        logic [15:0] v;
        int s0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(REG_STATUS, v);
        cmp(20'(v), 20'h0);
        cmp(20'(tx), 20'hF);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(REG_CHANNEL_SELECT, {14'h0, rows[i].ch});
            s0 = n_stat;
            rx_word(rows[i].ch, 1'b0, rows[i].d);
            cmp(20'(svc_req), 20'h1);
            cmp(20'(n_stat - s0), 20'h1);
            rd(REG_RX_DATA, v);
            cmp(20'(v), 20'(rows[i].d));
        end
        $display("test rows done");
        rx_word(3, 1'b0, 16'h1234);
        rx_word(3, 1'b0, 16'h4321);
        rd(REG_STATUS, v);
        cmp(20'(v[4]), 20'h1);
        rd(REG_RX_DATA, v);
        cmp(20'(v), 20'h4321);
        $display("test overrun done");
        wr(REG_ADDRESS_COMPARE, 16'h0015);
        wr(REG_RECEIVE_FUNCTION, 16'hD200);
        prog_rdy <= 1'b1;
        rx_word(3, 1'b1, 16'h2A00);
        cmp(20'(n_end), 20'h1);
        cmp(20'(svc_req), 20'h0);
        rd(REG_STATUS, v);
        cmp(20'(v[3:2]), 20'h3);
        rx_word(3, 1'b1, 16'h0000);
        cmp(20'({n_end[3:0], jump}), 20'h3);
        rd(REG_STATUS, v);
        cmp(20'(v[13]), 20'h1);
        cmp(20'(n_fn), 20'h1);
        $display("test tagged done");
        wr(REG_CHANNEL_SELECT, 16'h0000);
        s0 = n_svc;
        wr(REG_SIXTH_CONTROL, 16'h0008);
        repeat (10) @(posedge clk);
        cmp(20'(tr), 20'h1);
        cmp(20'(n_svc != s0), 20'h1);
        for (int t = 0; t < 2; t++) begin
            logic [15:0] d;
            d = t ? 16'h0F0F : 16'h5A3C;
            wr(REG_SEVENTH_CONTROL, {t[0], 11'h000, 4'h8});
            fork
                rs_u.take_word(0);
                begin
                    wr(REG_TX_DATA, d);
                    wr(REG_TX_DATA, 16'hFFFF);
                    rd(REG_STATUS, v);
                    cmp(20'(v[15]), 20'h1);
                end
            join
            cmp(rs_u.got_frame, {2'b11, d, t[0], 1'b0});
            rd(REG_STATUS, v);
            cmp(20'(v[15]), 20'h0);
        end
        $display("test transmit done");
        wr(REG_SEVENTH_CONTROL, 16'h2008);
        wr(REG_STATUS, 16'h0000);
        s0 = n_crc;
        rx_word(0, 1'b0, 16'h0001);
        rd(REG_CRC, v);
        cmp(20'(v), 20'(crc_of(16'h0001)));
        wr(REG_SEVENTH_CONTROL, 16'h2008);
        rd(REG_STATUS, v);
        cmp(20'(v[5]), 20'h1);
        cmp(20'(n_crc - s0), 20'h1);
        wr(REG_SIXTH_CONTROL, 16'h8008);
        fork
            rs_u.take_word(0);
            rx_word(0, 1'b0, 16'h3C5A);
        join
        cmp(rs_u.got_frame, {2'b11, 16'h3C5A, 2'b00});
        $display("test crc and repeat done");
        give_verdict();
    end
endmodule
bind tagged_serial_channel_transceiver serial_channel_checker #(
    .CHANNELS(CHANNELS)) chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
    .I_ADDR(I_ADDR), .I_WRITE(I_WRITE), .I_READ(I_READ),
    .O_TX_LINE(O_TX_LINE), .O_TERMINAL_READY(O_TERMINAL_READY),
    .O_REQUEST_TO_SEND(O_REQUEST_TO_SEND),
    .O_SERVICE_REQUEST(O_SERVICE_REQUEST), .O_DEVICE_END(O_DEVICE_END),
    .O_SERVICE_INTERRUPT(O_SERVICE_INTERRUPT),
    .O_CRC_INTERRUPT(O_CRC_INTERRUPT), .O_STATUS_CLOCK(O_STATUS_CLOCK));
